// file: rtl/sls_pkg.sv
package sls_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ  = 125_000_000;
    localparam int DEB_MS  = 10;
    localparam int DEB_CYC = CLK_HZ / 1000 * DEB_MS;
    localparam int LED_MS  = 50;
    localparam int LED_CYC = CLK_HZ / 1000 * LED_MS;
    localparam int CNT_W   = 24;
    // ------------------------------------------------------------
    // routing buffers
    // ------------------------------------------------------------
    localparam int BUF_BYTES     = 510;
    localparam int BUF_BYTES_OLD = 255;
    // ------------------------------------------------------------
    // register map and fields
    // ------------------------------------------------------------
    localparam int          ADDR_W     = 12;
    localparam logic [11:0] ADDR_CFG   = 12'h000;
    localparam logic [11:0] ADDR_STAT  = 12'h004;
    localparam logic [11:0] ADDR_ISTAT = 12'h008;
    localparam logic [11:0] ADDR_ICLR  = 12'h00c;
    localparam logic [11:0] ADDR_IEN   = 12'h010;
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_UPG_BIT  = 2;
    localparam int STAT_PROG_BIT = 3;
    localparam int STAT_SW_LSB   = 4;
    localparam int STAT_BOOT_BIT = 7;
    localparam int INT_PKT  = 0;
    localparam int INT_COLL = 1;
    localparam int INT_PROG = 2;
    localparam int INT_W    = 3;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SI_RS232 = 2'h0, SI_RS422 = 2'h1, SI_AUTO = 2'h2, SI_RS485 = 2'h3
    } sls_si_t;
    typedef enum logic [1:0] {BS_SETTLE = 2'b01, BS_RUN = 2'b10} sls_boot_t;
    // switch vector: [0] switch 1, [1] switch 2, [2] setup button
    function automatic sls_si_t sls_sw_decode(input logic [2:0] sw);
        if (sw[1:0] == 2'b11)
            return SI_RS485;
        else if (sw[1:0] == 2'b10)
            return SI_RS422;
        else
            return SI_RS232;
    endfunction : sls_sw_decode
endpackage : sls_pkg

// file: rtl/sls_top.sv
`timescale 1ns/100ps
`default_nettype none

module sls_rbuf #(
    parameter int W     = 8,
    parameter int DEPTH = sls_pkg::BUF_BYTES
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         nrst,
    // fill side
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    // drain side
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    generate
        if (DEPTH < 2 || W < 1)
            $error("sls_rbuf: depth or width too small");
    endgenerate

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0]           wp;
        logic [PW-1:0]           rp;
        logic [CW-1:0]           cnt;
        logic                    irdy;
        logic                    ov;
        logic [W-1:0]            od;
    } sls_rbuf_st_t;

    sls_rbuf_st_t q;
    sls_rbuf_st_t n;
    logic         push;
    logic         pop;

    always_comb
    begin
        n    = q;
        push = in_valid && q.irdy;
        pop  = (q.cnt != '0) && (!q.ov || out_ready);
        if (q.ov && out_ready)
            n.ov = 1'b0;
        if (pop)
        begin
            n.ov = 1'b1;
            n.od = q.mem[q.rp];
            n.rp = (q.rp == PW'(DEPTH - 1)) ? '0 : q.rp + PW'(1);
        end
        if (push)
        begin
            n.mem[q.wp] = in_data;
            n.wp = (q.wp == PW'(DEPTH - 1)) ? '0 : q.wp + PW'(1);
        end
        n.cnt  = q.cnt + CW'(push) - CW'(pop);
        n.irdy = n.cnt < CW'(DEPTH);
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            q <= '0;
        else
            q <= n;
    end

    assign in_ready  = q.irdy;
    assign out_valid = q.ov;
    assign out_data  = q.od;

    AST_BUF_FULL: assert property (@(posedge sys_clk) disable iff (!nrst)
        (q.cnt == CW'(DEPTH)) |-> !in_ready)
        else $error("buffer full but still ready");
endmodule : sls_rbuf

module sls_top #(
    parameter int DEB_CYC   = sls_pkg::DEB_CYC,
    parameter int LED_CYC   = sls_pkg::LED_CYC,
    parameter int BUF_DEPTH = sls_pkg::BUF_BYTES
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    // axi4-lite slave
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [31:0] s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             irq,
    // switches and setup button, high = on / pressed
    input  wire logic [2:0]  dip_sw,
    input  wire logic        setup_btn,
    output logic             upgrade_mode,
    output logic             prog_mode,
    // ethernet indicators
    input  wire logic        eth_pkt_rx,
    input  wire logic        eth_coll,
    output logic             led_eth_green,
    output logic             led_eth_red,
    // internal uart side
    input  wire logic        ser_txd,
    input  wire logic        ser_tx_busy,
    input  wire logic        ser_rts,
    output logic             ser_rxd,
    output logic             ser_cts,
    // line transceiver side
    output logic             ln_txd,
    output logic             ln_txd_oe,
    output logic             ln_rts,
    output logic             ln_rts_oe,
    input  wire logic        ln_rxd,
    input  wire logic        ln_cts,
    // network to serial bytes
    input  wire logic        n2s_in_valid,
    input  wire logic [7:0]  n2s_in_data,
    output logic             n2s_in_ready,
    output logic             n2s_out_valid,
    output logic [7:0]       n2s_out_data,
    input  wire logic        n2s_out_ready,
    // serial to network bytes
    input  wire logic        s2n_in_valid,
    input  wire logic [7:0]  s2n_in_data,
    output logic             s2n_in_ready,
    output logic             s2n_out_valid,
    output logic [7:0]       s2n_out_data,
    input  wire logic        s2n_out_ready
);
    localparam int CW = sls_pkg::CNT_W;
    generate
        if (DEB_CYC < 1 || DEB_CYC >= 2**CW || LED_CYC < 1 || LED_CYC >= 2**CW)
            $error("sls_top: timing count out of range");
    endgenerate

    typedef struct packed {
        sls_pkg::sls_boot_t bst;
        logic [2:0]         s1;
        logic [2:0]         s2;
        logic [2:0]         db;
        logic [CW-1:0]      dcnt;
        logic [2:0]         sw_lat;
        logic               upg;
        logic               prog;
        logic               btn_prev;
        logic [1:0]         cfg;
        sls_pkg::sls_si_t   md;
        logic [CW-1:0]      gcnt;
        logic [CW-1:0]      rcnt;
        logic               led_g;
        logic               led_r;
        logic               txd;
        logic               txd_oe;
        logic               rts;
        logic               rts_oe;
        logic               rxd;
        logic               cts;
        logic [2:0]         ist;
        logic [2:0]         ien;
        logic               irq;
        logic               awrdy;
        logic               wrdy;
        logic               aw_got;
        logic               w_got;
        logic [11:0]        awa;
        logic [31:0]        wd;
        logic [3:0]         ws;
        logic               bv;
        logic [1:0]         br;
        logic               arrdy;
        logic               rv;
        logic [31:0]        rd;
        logic [1:0]         rr;
    } sls_top_st_t;

    sls_top_st_t      q;
    sls_top_st_t      n;
    logic [2:0]       evt;
    sls_pkg::sls_si_t sw_md;

    // decode shared by the write and read paths; upper address bits alias
    function automatic logic reg_hit(input logic [11:0] a);
        return a == sls_pkg::ADDR_CFG || a == sls_pkg::ADDR_STAT ||
               a == sls_pkg::ADDR_ISTAT || a == sls_pkg::ADDR_ICLR ||
               a == sls_pkg::ADDR_IEN;
    endfunction : reg_hit

    always_comb
    begin
        n     = q;
        evt   = '0;
        sw_md = sls_pkg::sls_sw_decode(q.sw_lat);
        // --------------------------------------------------------
        // power-up sampling
        // --------------------------------------------------------
        // two-stage sync
        n.s1 = {setup_btn, dip_sw[1:0]};
        n.s2 = q.s1;
        case (q.bst)
            sls_pkg::BS_SETTLE:
            begin
                n.db   = q.s2;
                n.dcnt = (q.s2 == q.db) ? q.dcnt + CW'(1) : '0;
                if (q.s2 == q.db && q.dcnt == CW'(DEB_CYC - 1))
                begin
                    n.sw_lat   = q.db;
                    n.upg      = q.db[2];
                    n.btn_prev = q.db[2];
                    n.dcnt     = '0;
                    n.bst      = sls_pkg::BS_RUN;
                end
            end
            sls_pkg::BS_RUN:
            begin
                if (q.s2 != q.db)
                begin
                    n.dcnt = q.dcnt + CW'(1);
                    if (q.dcnt == CW'(DEB_CYC - 1))
                    begin
                        n.db   = q.s2;
                        n.dcnt = '0;
                    end
                end
                else
                    n.dcnt = '0;
                n.btn_prev = q.db[2];
                if (q.db[2] && !q.btn_prev && !q.upg)
                begin
                    n.prog                = 1'b1;
                    evt[sls_pkg::INT_PROG] = 1'b1;
                end
            end
            default:
                n.bst = sls_pkg::BS_SETTLE;
        endcase
        // --------------------------------------------------------
        // interface personality
        // --------------------------------------------------------
        // explicit setting overrides switches
        // switch 3 never reaches the decode
        n.md = (q.cfg == sls_pkg::SI_AUTO) ? sw_md : sls_pkg::sls_si_t'(q.cfg);
        n.txd = ser_txd;
        case (q.md)
            sls_pkg::SI_RS485:
            begin
                n.txd_oe = ser_tx_busy;
                n.rts    = 1'b0;
                n.rts_oe = 1'b0;
                n.cts    = 1'b1;
                n.rxd    = ser_tx_busy ? 1'b1 : ln_rxd;
            end
            default:
            begin
                n.txd_oe = 1'b1;
                n.rts    = ser_rts;
                n.rts_oe = 1'b1;
                n.cts    = ln_cts;
                n.rxd    = ln_rxd;
            end
        endcase
        // --------------------------------------------------------
        // ethernet indicators
        // --------------------------------------------------------
        // stretch pulses
        n.gcnt = eth_pkt_rx ? CW'(LED_CYC) : (q.gcnt != '0) ? q.gcnt - CW'(1) : '0;
        n.rcnt = eth_coll ? CW'(LED_CYC) : (q.rcnt != '0) ? q.rcnt - CW'(1) : '0;
        n.led_g = (n.gcnt == '0);
        n.led_r = (n.rcnt != '0);
        evt[sls_pkg::INT_PKT]  = eth_pkt_rx;
        evt[sls_pkg::INT_COLL] = eth_coll;
        // --------------------------------------------------------
        // axi4-lite write
        // --------------------------------------------------------
        if (s_axi_awvalid && q.awrdy)
        begin
            n.aw_got = 1'b1;
            n.awa    = s_axi_awaddr[11:0];
        end
        if (s_axi_wvalid && q.wrdy)
        begin
            n.w_got = 1'b1;
            n.wd    = s_axi_wdata;
            n.ws    = s_axi_wstrb;
        end
        if (q.bv && s_axi_bready)
            n.bv = 1'b0;
        if (q.aw_got && q.w_got && !q.bv)
        begin
            n.aw_got = 1'b0;
            n.w_got  = 1'b0;
            n.bv     = 1'b1;
            n.br     = reg_hit(q.awa) ? sls_pkg::RESP_OKAY : sls_pkg::RESP_SLVERR;
            if (q.ws[0])
            begin
                if (q.awa == sls_pkg::ADDR_CFG)
                    n.cfg = q.wd[1:0];
                if (q.awa == sls_pkg::ADDR_IEN)
                    n.ien = q.wd[2:0];
                if (q.awa == sls_pkg::ADDR_ICLR)
                    n.ist = q.ist & ~q.wd[2:0];
            end
        end
        // new events win over a clear in the same cycle
        n.ist   = n.ist | evt;
        n.irq   = |(n.ist & n.ien);
        n.awrdy = !n.aw_got && !n.bv;
        n.wrdy  = !n.w_got && !n.bv;
        // --------------------------------------------------------
        // axi4-lite read
        // --------------------------------------------------------
        if (q.rv && s_axi_rready)
            n.rv = 1'b0;
        if (s_axi_arvalid && q.arrdy)
        begin
            n.rv = 1'b1;
            n.rr = reg_hit(s_axi_araddr[11:0]) ? sls_pkg::RESP_OKAY : sls_pkg::RESP_SLVERR;
            case (s_axi_araddr[11:0])
                sls_pkg::ADDR_CFG:   n.rd = {30'h0, q.cfg};
                sls_pkg::ADDR_STAT:  n.rd = {24'h0, q.bst == sls_pkg::BS_RUN,
                                             q.sw_lat, q.prog, q.upg, q.md};
                sls_pkg::ADDR_ISTAT: n.rd = {29'h0, q.ist};
                sls_pkg::ADDR_IEN:   n.rd = {29'h0, q.ien};
                default:             n.rd = 32'h0;
            endcase
        end
        n.arrdy = !n.rv;
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            q       <= '0;
            q.bst   <= sls_pkg::BS_SETTLE;
            q.cfg   <= sls_pkg::SI_AUTO;
            q.led_g <= 1'b1;
            q.rxd   <= 1'b1;
            q.cts   <= 1'b1;
        end
        else
            q <= n;
    end

    assign s_axi_awready = q.awrdy;
    assign s_axi_wready  = q.wrdy;
    assign s_axi_bvalid  = q.bv;
    assign s_axi_bresp   = q.br;
    assign s_axi_arready = q.arrdy;
    assign s_axi_rvalid  = q.rv;
    assign s_axi_rdata   = q.rd;
    assign s_axi_rresp   = q.rr;
    assign irq           = q.irq;
    assign upgrade_mode  = q.upg;
    assign prog_mode     = q.prog;
    assign led_eth_green = q.led_g;
    assign led_eth_red   = q.led_r;
    assign ser_rxd       = q.rxd;
    assign ser_cts       = q.cts;
    assign ln_txd        = q.txd;
    assign ln_txd_oe     = q.txd_oe;
    assign ln_rts        = q.rts;
    assign ln_rts_oe     = q.rts_oe;

    // ------------------------------------------------------------
    // routing buffers
    // ------------------------------------------------------------
    // one buffer per direction
    sls_rbuf #(.W(8), .DEPTH(BUF_DEPTH)) u_n2s (
        .sys_clk(sys_clk), .nrst(nrst),
        .in_valid(n2s_in_valid), .in_data(n2s_in_data), .in_ready(n2s_in_ready),
        .out_valid(n2s_out_valid), .out_data(n2s_out_data), .out_ready(n2s_out_ready)
    );
    sls_rbuf #(.W(8), .DEPTH(BUF_DEPTH)) u_s2n (
        .sys_clk(sys_clk), .nrst(nrst),
        .in_valid(s2n_in_valid), .in_data(s2n_in_data), .in_ready(s2n_in_ready),
        .out_valid(s2n_out_valid), .out_data(s2n_out_data), .out_ready(s2n_out_ready)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_pkt_dark;
        !led_eth_green [*8];
    endsequence
    sequence s_coll_lit;
        led_eth_red [*8];
    endsequence

    AST_RS422_DRIVEN: assert property (@(posedge sys_clk) disable iff (!nrst)
        (q.md == sls_pkg::SI_RS422) |=> (ln_txd_oe && ln_rts_oe))
        else $error("rs422 pair not driven");
    AST_RS485_OE: assert property (@(posedge sys_clk) disable iff (!nrst)
        (q.md == sls_pkg::SI_RS485) |=> (ln_txd_oe == $past(ser_tx_busy)))
        else $error("rs485 driver enable wrong");
    AST_RS485_MUTE: assert property (@(posedge sys_clk) disable iff (!nrst)
        (q.md == sls_pkg::SI_RS485 && ser_tx_busy) |=> ser_rxd)
        else $error("rs485 echo not dropped");
    AST_RS485_LISTEN: assert property (@(posedge sys_clk) disable iff (!nrst)
        (q.md == sls_pkg::SI_RS485 && !ser_tx_busy) |=>
        (!ln_txd_oe && ser_rxd == $past(ln_rxd)))
        else $error("rs485 idle not listening");
    AST_RS485_NO_HS: assert property (@(posedge sys_clk) disable iff (!nrst)
        (q.md == sls_pkg::SI_RS485) |=> (!ln_rts_oe && ser_cts))
        else $error("rs485 handshake lines active");
    AST_SW_DECODE: assert property (@(posedge sys_clk) disable iff (!nrst)
        (q.cfg == sls_pkg::SI_AUTO && q.bst == sls_pkg::BS_RUN) ##1
        (q.cfg == sls_pkg::SI_AUTO) |-> (q.md == sls_pkg::sls_sw_decode(q.sw_lat)))
        else $error("switch decode wrong");
    AST_SW_FROZEN: assert property (@(posedge sys_clk) disable iff (!nrst)
        (q.bst == sls_pkg::BS_RUN) |=> ($stable(q.sw_lat) && $stable(upgrade_mode)))
        else $error("switches resampled after start");
    AST_CFG_WINS: assert property (@(posedge sys_clk) disable iff (!nrst)
        (q.cfg != sls_pkg::SI_AUTO) |=> (q.md == $past(q.cfg)))
        else $error("config override ignored");
    AST_GREEN_BLINK: assert property (@(posedge sys_clk) disable iff (!nrst)
        eth_pkt_rx |=> s_pkt_dark)
        else $error("green led not dark after packet");
    AST_RED_FLASH: assert property (@(posedge sys_clk) disable iff (!nrst)
        eth_coll |=> s_coll_lit)
        else $error("red led not lit after collision");
    AST_BOOT_BTN: assert property (@(posedge sys_clk) disable iff (!nrst)
        $rose(q.bst == sls_pkg::BS_RUN) |-> (upgrade_mode == q.sw_lat[2]))
        else $error("upgrade mode not from button");
    AST_PROG_REQ: assert property (@(posedge sys_clk) disable iff (!nrst)
        (q.bst == sls_pkg::BS_RUN && !q.upg && q.db[2] && !q.btn_prev) |=>
        (prog_mode && q.ist[sls_pkg::INT_PROG]))
        else $error("button press not seen");
endmodule : sls_top

`default_nettype wire

// file: test/sls_peer.sv
`timescale 1ns/100ps
`default_nettype none

module sls_peer (
    // clock
    input  wire logic sys_clk,
    // line pins
    input  wire logic ln_txd,
    input  wire logic ln_txd_oe,
    input  wire logic cts_in,
    output logic      ln_rxd,
    output logic      ln_cts
);
    logic pat;

    initial pat = 1'b0;
    // talker never idles, so a stale value cannot pass for a copy
    always @(posedge sys_clk) pat <= ~pat;
    assign ln_rxd = ln_txd_oe ? ln_txd : pat;
    assign ln_cts = cts_in;
endmodule : sls_peer

`default_nettype wire

// file: test/sls_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module sls_top_tb_top;
    localparam int LED_N = 10;
    localparam int BUF_N = 4;
    logic        sys_clk, nrst, irq, upgrade_mode, prog_mode, led_eth_green, led_eth_red;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [2:0]  dip_sw;
    logic        setup_btn, eth_pkt_rx, eth_coll, ser_txd, ser_tx_busy, ser_rts, ser_rxd;
    logic        ser_cts, ln_txd, ln_txd_oe, ln_rts, ln_rts_oe, ln_rxd, ln_cts, cts_in, prev;
    logic        n2s_in_valid, n2s_in_ready, n2s_out_valid, n2s_out_ready;
    logic        s2n_in_valid, s2n_in_ready, s2n_out_valid, s2n_out_ready;
    logic [7:0]  n2s_in_data, n2s_out_data, s2n_in_data, s2n_out_data, e;
    int          mismatches, n_compared, ng, nr;

    sls_top #(.DEB_CYC(4), .LED_CYC(LED_N), .BUF_DEPTH(BUF_N)) u_sls_top (
        .sys_clk, .nrst,
        .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
        .s_axi_rdata, .s_axi_rresp, .irq,
        .dip_sw, .setup_btn, .upgrade_mode, .prog_mode,
        .eth_pkt_rx, .eth_coll, .led_eth_green, .led_eth_red,
        .ser_txd, .ser_tx_busy, .ser_rts, .ser_rxd, .ser_cts,
        .ln_txd, .ln_txd_oe, .ln_rts, .ln_rts_oe, .ln_rxd, .ln_cts,
        .n2s_in_valid, .n2s_in_data, .n2s_in_ready,
        .n2s_out_valid, .n2s_out_data, .n2s_out_ready,
        .s2n_in_valid, .s2n_in_data, .s2n_in_ready,
        .s2n_out_valid, .s2n_out_data, .s2n_out_ready
    );
    sls_peer u_sls_peer (.sys_clk, .ln_txd, .ln_txd_oe, .cts_in, .ln_rxd, .ln_cts);

    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // ----------------------------------------
    // bus and check tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic axi_wr(input logic [31:0] a, input logic [31:0] v);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr  <= a;
        s_axi_wvalid  <= 1'b1;
        s_axi_wdata   <= v;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
            if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk({30'h0, s_axi_bresp}, 32'h0);
        s_axi_bready <= 1'b0;
        tick(1);
    endtask : axi_wr

    task automatic axi_rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] q);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr  <= a;
        s_axi_rready  <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        v = s_axi_rdata;
        q = s_axi_rresp;
        s_axi_rready <= 1'b0;
        tick(1);
    endtask : axi_rd

    task automatic test_done;
        $display("mismatches %0d compared %0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done

    // hang guard, far beyond the few hundred cycles of the tests
    initial
    begin
        #100000;
        mismatches++;
        test_done();
    end

    initial
    begin
        {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {setup_btn, eth_pkt_rx, eth_coll, ser_txd, ser_tx_busy, ser_rts, cts_in} = '0;
        {n2s_in_valid, n2s_out_ready, s2n_in_valid, s2n_out_ready, s2n_in_data} = '0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        n2s_in_data = 8'h10;
        s_axi_wstrb = 4'hf;
        dip_sw = 3'h7;
        mismatches = 0;
        n_compared = 0;
        tick(10);
        nrst <= 1'b1;
        tick(2);
        do axi_rd(32'h4, d, r); while (d[7] !== 1'b1);
        // active mode lags the latch flag by one cycle
        axi_rd(32'h4, d, r);
        chk({24'h0, d[7:0]}, 32'hb3);
        dip_sw <= 3'h0;
        tick(12);
        axi_rd(32'h4, d, r);
        chk({24'h0, d[7:0]}, 32'hb3);
        repeat (4)
        begin
            prev = ln_rxd;
            tick(1);
            chk({29'h0, ser_rxd, ln_txd_oe, ln_rts_oe}, {29'h0, prev, 2'b00});
        end
        chk({30'h0, ln_rts, ser_cts}, 32'h1);
        ser_tx_busy <= 1'b1;
        tick(2);
        repeat (4)
        begin
            tick(1);
            chk({30'h0, ser_rxd, ln_txd_oe}, 32'h3);
        end
        ser_tx_busy <= 1'b0;
        tick(3);
        chk({31'h0, ln_txd_oe}, 32'h0);
        axi_wr(32'h0, 32'h1);
        for (int v = 0; v < 2; v++)
        begin
            {ser_rts, cts_in, ser_txd} <= {3{v[0]}};
            tick(4);
            chk({27'h0, ln_rts, ser_cts, ln_txd, ln_txd_oe, ln_rts_oe},
                {27'h0, {3{v[0]}}, 2'b11});
        end
        axi_wr(32'h10, 32'h1);
        {eth_pkt_rx, eth_coll} <= 2'b11;
        tick(1);
        {eth_pkt_rx, eth_coll} <= 2'b00;
        ng = 0;
        nr = 0;
        repeat (LED_N + 4)
        begin
            tick(1);
            if (led_eth_green === 1'b0) ng++;
            if (led_eth_red === 1'b1) nr++;
        end
        chk(ng, LED_N);
        chk(nr, LED_N);
        chk({31'h0, irq}, 32'h1);
        axi_wr(32'hc, 32'h1);
        tick(1);
        chk({31'h0, irq}, 32'h0);
        axi_rd(32'h8, d, r);
        chk({29'h0, d[2:0]}, 32'h2);
        setup_btn <= 1'b1;
        tick(16);
        chk({30'h0, prog_mode, upgrade_mode}, 32'h2);
        axi_rd(32'h100, d, r);
        chk({d[29:0], r}, 32'h2);
        // far side stalls while the buffer fills
        n2s_in_valid <= 1'b1;
        ng = 0;
        repeat (12)
        begin
            tick(1);
            if (n2s_in_ready === 1'b1)
            begin
                ng++;
                n2s_in_data <= n2s_in_data + 8'h1;
            end
        end
        n2s_in_valid <= 1'b0;
        chk(ng, BUF_N + 1);
        n2s_out_ready <= 1'b1;
        e = 8'h10;
        nr = 0;
        repeat (12)
        begin
            tick(1);
            if (n2s_out_valid === 1'b1)
            begin
                chk({24'h0, n2s_out_data}, {24'h0, e});
                e++;
                nr++;
            end
        end
        chk(nr, BUF_N + 1);
        s2n_in_valid  <= 1'b1;
        s2n_in_data   <= 8'h5a;
        s2n_out_ready <= 1'b1;
        tick(1);
        s2n_in_valid <= 1'b0;
        tick(2);
        chk({22'h0, s2n_in_ready, s2n_out_valid, s2n_out_data}, {22'h0, 2'b11, 8'h5a});
        // second power-up with the button still held
        nrst <= 1'b0;
        tick(2);
        nrst <= 1'b1;
        tick(12);
        chk({30'h0, prog_mode, upgrade_mode}, 32'h1);
        test_done();
    end
endmodule : sls_top_tb_top

`default_nettype wire
